// file: rtl/bcrc_pkg.sv
// Package: register map, reset values and constants of the byte-serial CRC-16 generator
package bcrc_pkg;
    // Register byte offsets on the AHB-Lite bus
    localparam logic [3:0] BCRC_OFS_POLYNOMIAL_SELECT_CONTROL = 4'h0;
    localparam logic [3:0] BCRC_OFS_BYTE_INPUT = 4'h4;
    localparam logic [3:0] BCRC_OFS_SUM_LOW = 4'h8;
    localparam logic [3:0] BCRC_OFS_SUM_HIGH = 4'hC;
    // Field positions
    localparam int BCRC_POLYNOMIAL_SELECT_SELECT_BIT = 0;
    // Values after reset
    localparam logic BCRC_POLYNOMIAL_SELECT_SELECT_RST = 1'b0;
    localparam logic [7:0] BCRC_BYTE_INPUT_RST = 8'h00;
    localparam logic [15:0] BCRC_SUM_RST = 16'h0000;
    // Feedback constants of the two selectable generators
    localparam logic [15:0] BCRC_POLYNOMIAL_SELECT_CCITT = 16'h1021;
    localparam logic [15:0] BCRC_POLYNOMIAL_SELECT_CRC16 = 16'h8005;
    // Bit steps per input byte
    localparam int BCRC_BITS_PER_BYTE = 8;
    // Depth of the byte buffer in front of the engine
    localparam int BCRC_BUF_DEPTH = 2;
    // AHB transfer type with a valid transfer
    localparam logic [1:0] BCRC_HTRANS_NONSEQ = 2'h2;
    // Bus data-phase states
    typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ, PH_RESP} bcrc_phase_type;
endpackage : bcrc_pkg

// file: rtl/bcrc_stream_if.sv
// Interface: valid/ready byte stream between the bus front end, the buffer and the engine
`timescale 1ns/1ns
interface bcrc_stream_if #(parameter int WIDTH = 8);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : bcrc_stream_if

// file: rtl/bcrc_buf.sv
// Module: small FIFO with valid/ready on both sides
`timescale 1ns/1ns
module bcrc_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic mclk_i,
    input wire logic reset_i,
    bcrc_stream_if.snk in_if,
    bcrc_stream_if.src out_if,
    output logic empty_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW:0] count;
    } bcrc_buf_state_type;

    bcrc_buf_state_type st_ff;
    bcrc_buf_state_type nxt_st;
    logic push;
    logic pop;

    // Flags come straight from the count, so full and empty are exact
    assign in_if.ready = st_ff.count != (PW+1)'(DEPTH);
    assign out_if.valid = st_ff.count != '0;
    assign out_if.data = st_ff.mem[st_ff.rd_ptr];
    assign empty_o = st_ff.count == '0;
    assign push = in_if.valid && in_if.ready;
    assign pop = out_if.valid && out_if.ready;

    // Pointer wrap is explicit so any depth works, not only powers of two
    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wr_ptr] = in_if.data;
            nxt_st.wr_ptr = (st_ff.wr_ptr == PW'(DEPTH - 1)) ? '0 : st_ff.wr_ptr + 1'b1;
        end
        if (pop) begin
            nxt_st.rd_ptr = (st_ff.rd_ptr == PW'(DEPTH - 1)) ? '0 : st_ff.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            nxt_st.count = st_ff.count + 1'b1;
        end else if (pop && !push) begin
            nxt_st.count = st_ff.count - 1'b1;
        end
    end

    // State register
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule : bcrc_buf

// file: rtl/bcrc_top.sv
// Module: byte-serial CRC-16 generator with an AHB-Lite register slave
//
// Summary of operation
// - Polynomial select bit: 0 picks CRC-CCITT, 1 picks CRC-16; resets to 0.
// - Feedback constant is 8005H for CRC-16 and 1021H for CRC-CCITT.
// - Each byte input write folds the byte into the checksum and stores it back.
// - One byte update completes in one cycle; next access sees the new checksum.
// - Each update starts by XOR of the byte into the checksum high byte.
// - Each bit step shifts the temporary value left one, zero into the LSB.
// - If the pre-shift MSB is 0 keep it, else XOR with the polynomial constant.
// - Eight steps per byte; the last result becomes the new checksum.
// - Only the two fixed polynomials exist; no programmable polynomial.
// - Checksum high byte and low byte registers, both readable and writable.
// - Byte input register is 8-bit read/write, resets to zero.
// - Control bits seven to one are unimplemented and read as zero.
//
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
module bcrc_top
    import bcrc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic [31:0] hrdata_o,
    output logic hresp_o
);

    typedef struct packed {
        bcrc_phase_type phase;
        logic [3:0] dp_ofs;
        logic dp_map;
        logic polynomial_select_sel;
        logic [7:0] in_byte;
        logic [15:0] sum;
        logic [31:0] rdata;
    } bcrc_state_type;

    bcrc_state_type st_ff;
    bcrc_state_type nxt_st;

    bcrc_stream_if #(.WIDTH(8)) push_if ();
    bcrc_stream_if #(.WIDTH(8)) pop_if ();

    logic buf_empty;
    logic accept;
    logic wr_done;
    logic sum_wr;
    logic eng_ready;
    logic eng_pop;
    logic [15:0] polynomial_select_const;
    logic [31:0] read_mux;

    // One byte through all bit steps, unrolled into one cycle of logic
    function automatic logic [15:0] crc_next(input logic [15:0] sum, input logic [7:0] din,
                                             input logic [15:0] polynomial_select);
        logic [15:0] tmp;
        logic msb;
        tmp = sum ^ {din, 8'h00};
        for (int i = 0; i < BCRC_BITS_PER_BYTE; i++) begin
            msb = tmp[15];
            tmp = {tmp[14:0], 1'b0};
            if (msb) begin
                tmp = tmp ^ polynomial_select;
            end
        end
        return tmp;
    endfunction : crc_next

    // Only two fixed constants; nothing in the map can load another
    assign polynomial_select_const = st_ff.polynomial_select_sel ? BCRC_POLYNOMIAL_SELECT_CRC16 : BCRC_POLYNOMIAL_SELECT_CCITT;

    // Byte buffer between the bus and the engine
    bcrc_buf #(
        .WIDTH(8),
        .DEPTH(BCRC_BUF_DEPTH)
    ) u_buf (
        .mclk_i(mclk_i),
        .reset_i(reset_i),
        .in_if(push_if),
        .out_if(pop_if),
        .empty_o(buf_empty)
    );

    // Address phase decode; only word-aligned low offsets are mapped
    assign accept = hsel_i && hready_i && (htrans_i == BCRC_HTRANS_NONSEQ);

    // Read data multiplexer; unimplemented and upper bits read as zero
    always_comb begin
        read_mux = 32'h0000_0000;
        if (st_ff.dp_map) begin
            unique case (st_ff.dp_ofs)
                BCRC_OFS_POLYNOMIAL_SELECT_CONTROL: read_mux[BCRC_POLYNOMIAL_SELECT_SELECT_BIT] = st_ff.polynomial_select_sel;
                BCRC_OFS_BYTE_INPUT: read_mux[7:0] = st_ff.in_byte;
                BCRC_OFS_SUM_LOW: read_mux[7:0] = st_ff.sum[7:0];
                BCRC_OFS_SUM_HIGH: read_mux[7:0] = st_ff.sum[15:8];
                default: read_mux = 32'h0000_0000;
            endcase
        end
    end

    // Handshake terms of the data phase
    // Writes to control or checksum wait for the buffer to drain, so they never
    // overtake a byte that software wrote earlier
    always_comb begin
        push_if.valid = 1'b0;
        push_if.data = hwdata_i[7:0];
        hreadyout_o = 1'b1;
        sum_wr = 1'b0;
        unique case (st_ff.phase)
            PH_IDLE: hreadyout_o = 1'b1;
            PH_WRITE: begin
                if (st_ff.dp_map && st_ff.dp_ofs == BCRC_OFS_BYTE_INPUT) begin
                    push_if.valid = 1'b1;
                    hreadyout_o = push_if.ready;
                end else begin
                    hreadyout_o = buf_empty;
                    sum_wr = buf_empty && st_ff.dp_map &&
                             (st_ff.dp_ofs == BCRC_OFS_SUM_LOW || st_ff.dp_ofs == BCRC_OFS_SUM_HIGH);
                end
            end
            PH_READ: hreadyout_o = 1'b0;
            PH_RESP: hreadyout_o = 1'b1;
        endcase
    end

    assign wr_done = (st_ff.phase == PH_WRITE) && hreadyout_o;

    // Engine drains the buffer unless software is replacing the checksum
    assign eng_ready = !sum_wr;
    assign pop_if.ready = eng_ready;
    assign eng_pop = pop_if.valid && eng_ready;

    // Next-state logic for the whole block
    always_comb begin
        nxt_st = st_ff;
        // Engine: one buffered byte per cycle
        if (eng_pop) begin
            nxt_st.sum = crc_next(st_ff.sum, pop_if.data, polynomial_select_const);
        end
        // Data-phase write lands
        if (wr_done && st_ff.dp_map) begin
            unique case (st_ff.dp_ofs)
                BCRC_OFS_POLYNOMIAL_SELECT_CONTROL: nxt_st.polynomial_select_sel = hwdata_i[BCRC_POLYNOMIAL_SELECT_SELECT_BIT];
                BCRC_OFS_BYTE_INPUT: nxt_st.in_byte = hwdata_i[7:0];
                BCRC_OFS_SUM_LOW: nxt_st.sum[7:0] = hwdata_i[7:0];
                BCRC_OFS_SUM_HIGH: nxt_st.sum[15:8] = hwdata_i[7:0];
                default: nxt_st.sum = nxt_st.sum;
            endcase
        end
        // Reads wait until no byte is in flight, then sample without side effect
        if (st_ff.phase == PH_READ && buf_empty) begin
            nxt_st.rdata = read_mux;
            nxt_st.phase = PH_RESP;
        end
        // Address phase accepted when our previous data phase ends
        if (hreadyout_o) begin
            if (accept) begin
                nxt_st.phase = hwrite_i ? PH_WRITE : PH_READ;
                nxt_st.dp_ofs = haddr_i[3:0];
                nxt_st.dp_map = (haddr_i[31:4] == 28'h000_0000) && (haddr_i[1:0] == 2'b00);
            end else begin
                nxt_st.phase = PH_IDLE;
            end
        end
    end

    // State register with documented reset values
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st_ff.phase <= PH_IDLE;
            st_ff.dp_ofs <= 4'h0;
            st_ff.dp_map <= 1'b0;
            st_ff.polynomial_select_sel <= BCRC_POLYNOMIAL_SELECT_SELECT_RST;
            st_ff.in_byte <= BCRC_BYTE_INPUT_RST;
            st_ff.sum <= BCRC_SUM_RST;
            st_ff.rdata <= 32'h0000_0000;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Read data from a flop; the response is always OKAY
    assign hrdata_o = st_ff.rdata;
    assign hresp_o = 1'b0;

    // Checks on the block's own behaviour
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);

    logic rd_ctrl_resp;
    assign rd_ctrl_resp = st_ff.phase == PH_RESP && st_ff.dp_map && st_ff.dp_ofs == BCRC_OFS_POLYNOMIAL_SELECT_CONTROL;

    // Data-phase decodes shared by the checks; a read samples once the buffer is empty
    logic dp_ctrl;
    logic dp_input;
    logic dp_low;
    logic dp_high;
    logic rd_sample;
    assign dp_ctrl = st_ff.dp_map && st_ff.dp_ofs == BCRC_OFS_POLYNOMIAL_SELECT_CONTROL;
    assign dp_input = st_ff.dp_map && st_ff.dp_ofs == BCRC_OFS_BYTE_INPUT;
    assign dp_low = st_ff.dp_map && st_ff.dp_ofs == BCRC_OFS_SUM_LOW;
    assign dp_high = st_ff.dp_map && st_ff.dp_ofs == BCRC_OFS_SUM_HIGH;
    assign rd_sample = st_ff.phase == PH_READ && buf_empty;

    AST_CTRL_READ_POLYNOMIAL_SELECT: assert property (
        st_ff.phase == PH_READ && buf_empty && st_ff.dp_map && st_ff.dp_ofs == BCRC_OFS_POLYNOMIAL_SELECT_CONTROL
        |=> hrdata_o[0] == $past(st_ff.polynomial_select_sel))
        else $error("control read does not show the polynomial select bit");

    AST_POLYNOMIAL_SELECT_CONST: assert property (
        polynomial_select_const == (st_ff.polynomial_select_sel ? 16'h8005 : 16'h1021))
        else $error("feedback constant does not match the selection");

    AST_BYTE_UPDATE: assert property (
        eng_pop |=> st_ff.sum == crc_next($past(st_ff.sum), $past(pop_if.data), $past(polynomial_select_const)))
        else $error("checksum not updated from the popped byte");

    AST_ONE_CYCLE: assert property (
        push_if.valid && push_if.ready |=> eng_pop)
        else $error("byte update took more than one cycle");

    AST_SINGLE_BYTE: assert property (
        eng_pop && st_ff.sum == 16'h0000 && pop_if.data == 8'h01 |=> st_ff.sum == $past(polynomial_select_const))
        else $error("byte 01H from zero did not yield the polynomial");

    AST_SUM_LOW_WRITE: assert property (
        wr_done && st_ff.dp_map && st_ff.dp_ofs == BCRC_OFS_SUM_LOW
        |=> st_ff.sum[7:0] == $past(hwdata_i[7:0]) && $stable(st_ff.sum[15:8]))
        else $error("checksum low byte write not applied");

    AST_CTRL_RESERVED_ZERO: assert property (
        rd_ctrl_resp |-> hrdata_o[31:1] == 31'h0000_0000)
        else $error("reserved control bits read nonzero");

    AST_READ_NO_SIDE: assert property (
        st_ff.phase == PH_READ && !eng_pop |=> $stable(st_ff.sum) && $stable(st_ff.polynomial_select_sel))
        else $error("read changed the calculation state");

    AST_INPUT_REG: assert property (
        wr_done && st_ff.dp_map && st_ff.dp_ofs == BCRC_OFS_BYTE_INPUT
        |=> st_ff.in_byte == $past(hwdata_i[7:0]))
        else $error("byte input register not loaded");

    AST_READ_WAIT: assert property (
        st_ff.phase == PH_READ |-> ##[1:3] st_ff.phase == PH_RESP)
        else $error("read answer not given within three cycles");

    AST_CTRL_WRITE: assert property (
        wr_done && dp_ctrl |=> st_ff.polynomial_select_sel == $past(hwdata_i[BCRC_POLYNOMIAL_SELECT_SELECT_BIT]))
        else $error("polynomial select write not applied");

    AST_POLYNOMIAL_SELECT_HOLD: assert property (
        !(wr_done && dp_ctrl) |=> $stable(st_ff.polynomial_select_sel))
        else $error("polynomial select changed without a control write");

    AST_CCITT_ONE: assert property (
        eng_pop && !st_ff.polynomial_select_sel && st_ff.sum == 16'h0000 && pop_if.data == 8'h01 |=> st_ff.sum == 16'h1021)
        else $error("CCITT feedback constant wrong");

    AST_CRC16_ONE: assert property (
        eng_pop && st_ff.polynomial_select_sel && st_ff.sum == 16'h0000 && pop_if.data == 8'h01 |=> st_ff.sum == 16'h8005)
        else $error("CRC-16 feedback constant wrong");

    AST_READ_NOT_READY: assert property (
        st_ff.phase == PH_READ |-> !hreadyout_o)
        else $error("read answered before the checksum settled");

    AST_NO_STALL: assert property (
        !buf_empty |-> eng_pop)
        else $error("engine left a buffered byte waiting");

    AST_BUF_ROOM: assert property (
        push_if.valid |-> push_if.ready)
        else $error("byte input write stalled on a full buffer");

    AST_ZERO_BYTE: assert property (
        eng_pop && st_ff.sum == 16'h0000 && pop_if.data == 8'h00 |=> st_ff.sum == 16'h0000)
        else $error("zero byte from zero changed the checksum");

    AST_CCITT_TWO: assert property (
        eng_pop && !st_ff.polynomial_select_sel && st_ff.sum == 16'h0000 && pop_if.data == 8'h02 |=> st_ff.sum == 16'h2042)
        else $error("CCITT shift sequence wrong for byte 02H");

    AST_CRC16_TWO: assert property (
        eng_pop && st_ff.polynomial_select_sel && st_ff.sum == 16'h0000 && pop_if.data == 8'h02 |=> st_ff.sum == 16'h800F)
        else $error("CRC-16 conditional feedback wrong for byte 02H");

    AST_SUM_HIGH_WRITE: assert property (
        wr_done && dp_high |=> st_ff.sum[15:8] == $past(hwdata_i[7:0]) && $stable(st_ff.sum[7:0]))
        else $error("checksum high byte write not applied");

    AST_SUM_HOLD: assert property (
        !eng_pop && !(wr_done && (dp_low || dp_high)) |=> $stable(st_ff.sum))
        else $error("checksum changed without a byte or a load");

    AST_LOAD_NO_POP: assert property (
        sum_wr |-> !eng_pop)
        else $error("engine ran while software loaded the checksum");

    AST_SUM_LOW_READ: assert property (
        rd_sample && dp_low |=> hrdata_o == {24'h00_0000, $past(st_ff.sum[7:0])})
        else $error("checksum low byte read wrong");

    AST_SUM_HIGH_READ: assert property (
        rd_sample && dp_high |=> hrdata_o == {24'h00_0000, $past(st_ff.sum[15:8])})
        else $error("checksum high byte read wrong");

    AST_INPUT_READ: assert property (
        rd_sample && dp_input |=> hrdata_o == {24'h00_0000, $past(st_ff.in_byte)})
        else $error("byte input register read wrong");

    AST_INPUT_HOLD: assert property (
        !(wr_done && dp_input) |=> $stable(st_ff.in_byte))
        else $error("byte input register changed without a write");

    AST_RESET_STATE: assert property (
        $fell(reset_i) |-> st_ff.sum == 16'h0000 && st_ff.in_byte == 8'h00 && !st_ff.polynomial_select_sel)
        else $error("registers not zero after reset");

    AST_UNMAPPED_READ: assert property (
        rd_sample && !st_ff.dp_map |=> hrdata_o == 32'h0000_0000)
        else $error("unmapped read returned data");

    AST_RDATA_HOLD: assert property (
        !rd_sample |=> $stable(hrdata_o))
        else $error("read data changed outside a read");

    COV_CCITT_BYTE: cover property (eng_pop && !st_ff.polynomial_select_sel);
    COV_CRC16_BYTE: cover property (eng_pop && st_ff.polynomial_select_sel);
    COV_BACK_TO_BACK: cover property (eng_pop ##1 eng_pop);
    COV_READ_SUM: cover property (st_ff.phase == PH_RESP && st_ff.dp_ofs == BCRC_OFS_SUM_HIGH);
    COV_SUM_LOAD: cover property (sum_wr);

endmodule : bcrc_top

// file: dv/bcrc_top_tb.sv
// Testbench: register-level checks of the byte-serial CRC generator over AHB-Lite
`timescale 1ns/1ns
module bcrc_top_tb;
    import bcrc_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0000_0000;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] hwdata_i = 32'h0000_0000;
    logic hreadyout_o;
    logic [31:0] hrdata_o;
    logic hresp_o;
    int err_count = 0;
    int tests_run = 0;
    logic [31:0] rd;
    logic [15:0] sum;
    logic [15:0] seq_exp [2][4] = '{'{16'hFF9F, 16'hBBC3, 16'hA367, 16'hD0FA},
                                    '{16'h0110, 16'h91F1, 16'hF2DE, 16'h5C43}};
    logic [7:0] seq_in [4] = '{8'h78, 8'h56, 8'h34, 8'h12};
    // Documented single-byte results from a zero checksum, CCITT row then CRC-16 row
    logic [15:0] one_exp [2][8] = '{
        '{16'h0000, 16'h1021, 16'h2042, 16'h3063, 16'h4084, 16'h50A5, 16'h60C6, 16'h70E7},
        '{16'h0000, 16'h8005, 16'h800F, 16'h000A, 16'h801B, 16'h001E, 16'h0014, 16'h8011}};
    // Same byte stream as two program words
    logic [15:0] prog_words [2] = '{16'h5678, 16'h1234};

    // One slave, so its ready is the bus ready
    bcrc_top u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hrdata_o(hrdata_o), .hresp_o(hresp_o));

    // 100 MHz clock
    always #5 mclk_i = ~mclk_i;

    // Independent model of one byte update, MSB first
    function automatic logic [15:0] ref_crc(input logic [15:0] s, input logic [7:0] b, input logic sel);
        logic [15:0] t;
        logic msb;
        t = s ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            msb = t[15];
            t = {t[14:0], 1'b0};
            if (msb) begin
                t = t ^ (sel ? BCRC_POLYNOMIAL_SELECT_CRC16 : BCRC_POLYNOMIAL_SELECT_CCITT);
            end
        end
        return t;
    endfunction : ref_crc

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    // Waits for a ready edge; levels are taken on the falling edge, stable up to the rising one
    task automatic wait_ready(output logic [31:0] data);
        logic r;
        do begin
            @(negedge mclk_i);
            r = hreadyout_o;
            data = hrdata_o;
            @(posedge mclk_i);
        end while (r !== 1'b1);
    endtask : wait_ready

    // Single AHB-Lite transfer: address phase, then data phase
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata);
        logic [31:0] dummy;
        hsel_i <= 1'b1;
        htrans_i <= BCRC_HTRANS_NONSEQ;
        haddr_i <= addr;
        hwrite_i <= wr;
        wait_ready(dummy);
        htrans_i <= 2'h0;
        hsel_i <= 1'b0;
        hwdata_i <= wdata;
        wait_ready(rdata);
        chk({31'h0, hresp_o}, 32'h0, "response");
    endtask : xfer

    task automatic wr(input logic [31:0] addr, input logic [7:0] d);
        logic [31:0] unused;
        xfer(1'b1, addr, {24'h0, d}, unused);
    endtask : wr

    task automatic rd_sum(output logic [15:0] s);
        logic [31:0] hi;
        logic [31:0] lo;
        xfer(1'b0, BCRC_OFS_SUM_HIGH, 32'h0, hi);
        xfer(1'b0, BCRC_OFS_SUM_LOW, 32'h0, lo);
        chk({hi[31:8], lo[31:8]}, 32'h0, "upper bits");
        s = {hi[7:0], lo[7:0]};
    endtask : rd_sum

    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (40000) @(posedge mclk_i);
        err_count++;
        $display("BAD %0t watchdog expired", $time);
        close_out();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge mclk_i);
        reset_i <= 1'b0;
        @(posedge mclk_i);
        // Reset values and an unmapped place
        xfer(1'b0, BCRC_OFS_POLYNOMIAL_SELECT_CONTROL, 32'h0, rd);
        chk(rd, 32'h0, "control reset");
        xfer(1'b0, BCRC_OFS_BYTE_INPUT, 32'h0, rd);
        chk(rd, 32'h0, "input reset");
        rd_sum(sum);
        chk(sum, BCRC_SUM_RST, "sum reset");
        wr(32'h0000_0010, 8'hA5);
        xfer(1'b0, 32'h0000_0010, 32'h0, rd);
        chk(rd, 32'h0, "unmapped");
        $display("test reset done");
        // Upper control bits unimplemented
        wr(BCRC_OFS_POLYNOMIAL_SELECT_CONTROL, 8'hFF);
        xfer(1'b0, BCRC_OFS_POLYNOMIAL_SELECT_CONTROL, 32'h0, rd);
        chk(rd, 32'h1, "control bits");
        $display("test control done");
        // Single bytes from zero, both generators
        for (int sel = 0; sel < 2; sel++) begin
            wr(BCRC_OFS_POLYNOMIAL_SELECT_CONTROL, 8'(sel));
            for (int b = 0; b < 8; b++) begin
                wr(BCRC_OFS_SUM_HIGH, 8'h00);
                wr(BCRC_OFS_SUM_LOW, 8'h00);
                wr(BCRC_OFS_BYTE_INPUT, 8'(b));
                rd_sum(sum);
                chk(sum, one_exp[sel][b], "single byte");
                if (b == 1) begin
                    chk(sum, sel ? 16'h8005 : 16'h1021, "one gives polynomial_select");
                end
            end
            // Four bytes, read after each update
            wr(BCRC_OFS_SUM_HIGH, 8'h00);
            wr(BCRC_OFS_SUM_LOW, 8'h00);
            for (int k = 0; k < 4; k++) begin
                wr(BCRC_OFS_BYTE_INPUT, seq_in[k]);
                rd_sum(sum);
                chk(sum, seq_exp[sel][k], "sequence");
            end
            // Two program words, low byte first, read once at the end
            wr(BCRC_OFS_SUM_HIGH, 8'h00);
            wr(BCRC_OFS_SUM_LOW, 8'h00);
            for (int w = 0; w < 2; w++) begin
                wr(BCRC_OFS_BYTE_INPUT, prog_words[w][7:0]);
                wr(BCRC_OFS_BYTE_INPUT, prog_words[w][15:8]);
            end
            rd_sum(sum);
            chk(sum, seq_exp[sel][3], "word sequence");
            $display("test generator %0d done", sel);
        end
        // Software load of the pair, reads without side effect, then an update from it
        wr(BCRC_OFS_SUM_HIGH, 8'h12);
        wr(BCRC_OFS_SUM_LOW, 8'h34);
        rd_sum(sum);
        rd_sum(sum);
        chk(sum, 16'h1234, "loaded sum");
        wr(BCRC_OFS_BYTE_INPUT, 8'hC3);
        xfer(1'b0, BCRC_OFS_BYTE_INPUT, 32'h0, rd);
        chk(rd, 32'h0000_00C3, "input readback");
        rd_sum(sum);
        chk(sum, ref_crc(16'h1234, 8'hC3, 1'b1), "update from load");
        $display("test load done");
        // Reset in mid-run must bring every register back to zero
        reset_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        reset_i <= 1'b0;
        @(posedge mclk_i);
        xfer(1'b0, BCRC_OFS_POLYNOMIAL_SELECT_CONTROL, 32'h0, rd);
        chk(rd, 32'h0, "control after reset");
        xfer(1'b0, BCRC_OFS_BYTE_INPUT, 32'h0, rd);
        chk(rd, 32'h0, "input after reset");
        rd_sum(sum);
        chk(sum, BCRC_SUM_RST, "sum after reset");
        $display("test mid reset done");
        close_out();
    end
endmodule : bcrc_top_tb
